/* File: core/amp_supervisor.v */
// supervisory logic of a networked amplifier control module: address, lamps,
// contacts, standby and protection, with registers on an axi4-lite slave
// assumes all inputs synchronous to aclk; stored state survives in the supply
// domain, so the retained standby bit arrives on a port from non-volatile keep
//
// Summary of operation
// - address is high digit then low digit
// - only addresses 1 through 250 are valid
// - address zero stays off the network
// - address zero clears processing, routes straight through
// - detached unit pulses status lamp every three seconds
// - status lamp lit 100 ms per transmission while the traffic seen bit is set
// - identify request flashes status lamp fast
// - contact inputs idle high, asserted when grounded
// - software assigns each contact input a function
// - contact outputs float idle, pull low active
// - contact outputs report internal operating conditions
// - remote input high runs, low means standby
// - standby keeps auxiliary supply, drops main supply
// - protection trip lights lamp, opens output relays
// - thermal trip recovers by itself when cleared
// - activity lamp near full drive, off on protection
// - limit lamp follows the dynamic limiter
// - relays stay open two seconds after power up
// - power up restores previous standby state
//
// Design decisions made here: the address map and the AXI4-Lite interface to the registers.
`include "amp_supervisor_map.vh"

module amp_supervisor #(
   parameter BLINK_CYC = `MS_CYCLES(`BLINK_MS),
   parameter LAMP_CYC = `MS_CYCLES(`LAMP_MIN_MS),
   parameter MUTE_CYC = `MS_CYCLES(`MUTE_MS),
   parameter FAST_CYC = `MS_CYCLES(`FAST_MS),
   parameter PULSE_CYC = `MS_CYCLES(`PULSE_MS),
   parameter DEB_CYC = `MS_CYCLES(`DEBOUNCE_MS)
) (
   input wire aclk,
   input wire aresetn,
   // axi4-lite slave
   input wire [11:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [11:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // selectors and pins
   input wire [3:0] addr_high_sel,
   input wire [3:0] addr_low_sel,
   input wire contact_input_first,
   input wire contact_input_second,
   input wire remote_power_in,
   input wire standby_retained,
   input wire can_traffic_seen,
   input wire can_tx_pulse,
   input wire prot_thermal,
   input wire prot_other,
   input wire short_circuit,
   input wire signal_near_full,
   input wire limiter_engaged,
   input wire temp_critical,
   input wire limit_crossed,
   input wire fault_seen,
   output reg contact_output_first_oe,
   output reg contact_output_first_o,
   output reg contact_output_second_oe,
   output reg contact_output_second_o,
   output reg status_lamp,
   output reg protect_lamp,
   output reg out_lamp,
   output reg limit_lamp,
   output reg standby_lamp,
   output reg output_relay_on,
   output reg main_supply_on,
   output reg aux_supply_on,
   output reg fans_full,
   output reg network_enable,
   output reg process_enable,
   output reg process_clear,
   output reg preset_recall_pulse,
   output reg param_step_pulse
);
   // ========================================
   // input debounce
   // debounce shared by both selectors and contacts; one counter per input
   wire [10:0] raw_in = {remote_power_in, contact_input_second, contact_input_first,
                         addr_high_sel, addr_low_sel};
   wire [10:0] deb_in;
   genvar gi;
   generate
      for (gi = 0; gi < 11; gi = gi + 1) begin : g_deb
         reg stable_ff;
         reg [31:0] cnt_ff;
         // a change must hold for the whole window before it is believed
         always @(posedge aclk) begin
            if (!aresetn) begin
               stable_ff <= 1'b1;
               cnt_ff <= 32'h0000_0000;
            end else if (raw_in[gi] == stable_ff) begin
               cnt_ff <= 32'h0000_0000;
            end else if (cnt_ff >= DEB_CYC - 1) begin
               stable_ff <= raw_in[gi];
               cnt_ff <= 32'h0000_0000;
            end else begin
               cnt_ff <= cnt_ff + 32'h0000_0001;
            end
         end
         assign deb_in[gi] = stable_ff;
      end
   endgenerate
   // ========================================
   // address capture at power-up
   reg [7:0] net_addr_ff;
   reg addr_valid_ff, addr_zero_ff, addr_done_ff;
   reg [31:0] mute_cnt_ff;
   reg muted_ff;
   // address is taken once the debounce has settled, then frozen until reset
   always @(posedge aclk) begin
      if (!aresetn) begin
         net_addr_ff <= 8'h00;
         addr_done_ff <= 1'b0;
         addr_valid_ff <= 1'b0;
         addr_zero_ff <= 1'b1;
      end else if (!addr_done_ff && mute_cnt_ff == DEB_CYC * 2) begin
         net_addr_ff <= {deb_in[7:4], deb_in[3:0]};
         addr_done_ff <= 1'b1;
         addr_zero_ff <= ({deb_in[7:4], deb_in[3:0]} == `ADDR_STANDALONE);
         addr_valid_ff <= deb_in[7:0] != `ADDR_STANDALONE && deb_in[7:0] <= `ADDR_MAX;
      end
   end
   // ========================================
   // power-up mute of the outputs
   always @(posedge aclk) begin
      if (!aresetn) begin
         mute_cnt_ff <= 32'h0000_0000;
         muted_ff <= 1'b1;
      end else if (mute_cnt_ff >= MUTE_CYC - 1) begin
         muted_ff <= 1'b0;
      end else begin
         mute_cnt_ff <= mute_cnt_ff + 32'h0000_0001;
      end
   end
   // ========================================
   // registers
   reg [31:0] control_ff; // [0] standby, [1] identify, [2] process enable
   reg [31:0] contact_func_ff; // [1:0] first input, [3:2] second input
   reg [31:0] cond_map_ff; // [3:0] first output, [7:4] second output sources
   reg standby_ff, restored_ff;
   wire in1_act = ~deb_in[8];
   wire in2_act = ~deb_in[9];
   wire remote_low = ~deb_in[10];
   reg in1_q_ff, in2_q_ff;
   wire in1_rise = in1_act & ~in1_q_ff;
   wire in2_rise = in2_act & ~in2_q_ff;
   reg [31:0] traffic_ff; // bit0 traffic seen, bit1 transmitted, sticky
   // write channel: address and data accepted in either order
   reg aw_hold_ff, w_hold_ff;
   reg [11:0] aw_addr_ff;
   reg [31:0] w_data_ff;
   reg [3:0] w_strb_ff;
   wire wr_go = aw_hold_ff & w_hold_ff & ~s_axi_bvalid;
   wire [31:0] wmask = {{8{w_strb_ff[3]}}, {8{w_strb_ff[2]}},
                        {8{w_strb_ff[1]}}, {8{w_strb_ff[0]}}};
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_ff <= 1'b0;
         w_hold_ff <= 1'b0;
         aw_addr_ff <= 12'h000;
         w_data_ff <= 32'h0000_0000;
         w_strb_ff <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `AXI_OKAY;
      end else begin
         s_axi_awready <= ~aw_hold_ff & ~s_axi_awready & s_axi_awvalid;
         s_axi_wready <= ~w_hold_ff & ~s_axi_wready & s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_ff <= 1'b1;
            aw_addr_ff <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold_ff <= 1'b1;
            w_data_ff <= s_axi_wdata;
            w_strb_ff <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_hold_ff <= 1'b0;
            w_hold_ff <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_addr_ff <= `REG_PROCESS && aw_addr_ff[1:0] == 2'b00) ?
                           `AXI_OKAY : `AXI_DECERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end
   // software registers, standby state and contact input functions
   always @(posedge aclk) begin
      if (!aresetn) begin
         control_ff <= `CONTROL_RST;
         contact_func_ff <= `CONTACT_FUNC_RST;
         cond_map_ff <= `COND_MAP_RST;
         standby_ff <= 1'b0;
         restored_ff <= 1'b0;
         traffic_ff <= 32'h0000_0000;
         in1_q_ff <= 1'b0;
         in2_q_ff <= 1'b0;
         preset_recall_pulse <= 1'b0;
         param_step_pulse <= 1'b0;
      end else begin
         in1_q_ff <= in1_act;
         in2_q_ff <= in2_act;
         preset_recall_pulse <= (in1_rise && contact_func_ff[1:0] == `FUNC_PRESET) ||
                                (in2_rise && contact_func_ff[3:2] == `FUNC_PRESET);
         param_step_pulse <= (in1_rise && contact_func_ff[1:0] == `FUNC_PARAM) ||
                             (in2_rise && contact_func_ff[3:2] == `FUNC_PARAM);
         if (!restored_ff) begin
            standby_ff <= standby_retained;
            restored_ff <= 1'b1;
         end else if (wr_go && aw_addr_ff == `REG_CONTROL && w_strb_ff[0]) begin
            standby_ff <= w_data_ff[0];
         end else if (in1_rise && contact_func_ff[1:0] == `FUNC_POWER) begin
            standby_ff <= ~standby_ff;
         end else if (in2_rise && contact_func_ff[3:2] == `FUNC_POWER) begin
            standby_ff <= ~standby_ff;
         end
         if (wr_go && aw_addr_ff == `REG_CONTROL) begin
            control_ff <= (control_ff & ~wmask) | (w_data_ff & wmask);
         end
         if (wr_go && aw_addr_ff == `REG_CONTACT_FUNC) begin
            contact_func_ff <= (contact_func_ff & ~wmask) | (w_data_ff & wmask);
         end
         if (wr_go && aw_addr_ff == `REG_COND_MAP) begin
            cond_map_ff <= (cond_map_ff & ~wmask) | (w_data_ff & wmask);
         end
         // hardware set wins over a write-one clear in the same cycle
         traffic_ff[0] <= can_traffic_seen | (traffic_ff[0] &
            ~(wr_go && aw_addr_ff == `REG_TRAFFIC && w_strb_ff[0] && w_data_ff[0]));
         traffic_ff[1] <= can_tx_pulse | (traffic_ff[1] &
            ~(wr_go && aw_addr_ff == `REG_TRAFFIC && w_strb_ff[0] && w_data_ff[1]));
      end
   end
   // ========================================
   // read channel
   wire protect_now = prot_thermal | prot_other;
   wire standby_now = standby_ff | remote_low;
   wire [31:0] status_word = {8'h00, net_addr_ff, 5'h00, in2_act, in1_act,
                              remote_low, limiter_engaged, short_circuit,
                              prot_thermal, prot_other, muted_ff, standby_now,
                              addr_zero_ff, addr_valid_ff};
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `AXI_OKAY;
      end else begin
         s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `AXI_OKAY;
            case (s_axi_araddr)
               `REG_STATUS: s_axi_rdata <= status_word;
               `REG_CONTROL: s_axi_rdata <= {control_ff[31:1], standby_ff};
               `REG_CONTACT_FUNC: s_axi_rdata <= contact_func_ff;
               `REG_COND_MAP: s_axi_rdata <= cond_map_ff;
               `REG_TRAFFIC: s_axi_rdata <= traffic_ff;
               `REG_PROCESS: s_axi_rdata <= {30'h0000_0000, process_clear,
                                              process_enable};
               default: begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= `AXI_DECERR;
               end
            endcase
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
   // ========================================
   // status lamp timing
   reg [31:0] blink_cnt_ff, lamp_cnt_ff, fast_cnt_ff;
   reg fast_ph_ff;
   always @(posedge aclk) begin
      if (!aresetn) begin
         blink_cnt_ff <= 32'h0000_0000;
         lamp_cnt_ff <= 32'h0000_0000;
         fast_cnt_ff <= 32'h0000_0000;
         fast_ph_ff <= 1'b0;
      end else begin
         blink_cnt_ff <= (blink_cnt_ff >= BLINK_CYC - 1) ? 32'h0000_0000
                         : blink_cnt_ff + 32'h0000_0001;
         if (fast_cnt_ff >= FAST_CYC - 1) begin
            fast_cnt_ff <= 32'h0000_0000;
            fast_ph_ff <= ~fast_ph_ff;
         end else begin
            fast_cnt_ff <= fast_cnt_ff + 32'h0000_0001;
         end
         // each transmission while traffic_ff[0] is set restarts the hold, so the lamp never drops early
         if (can_tx_pulse && traffic_ff[0])
            lamp_cnt_ff <= LAMP_CYC;
         else if (lamp_cnt_ff != 32'h0000_0000)
            lamp_cnt_ff <= lamp_cnt_ff - 32'h0000_0001;
      end
   end
   // ========================================
   // outputs, all registered
   wire [3:0] cond_vec = {fault_seen, limit_crossed, temp_critical, protect_now};
   wire contact_output_first_act = |(cond_vec & cond_map_ff[3:0]);
   wire contact_output_second_act = |(cond_vec & cond_map_ff[7:4]);
   always @(posedge aclk) begin
      if (!aresetn) begin
         contact_output_first_oe <= 1'b0;
         contact_output_first_o <= 1'b0;
         contact_output_second_oe <= 1'b0;
         contact_output_second_o <= 1'b0;
         status_lamp <= 1'b0;
         protect_lamp <= 1'b1;
         out_lamp <= 1'b0;
         limit_lamp <= 1'b0;
         standby_lamp <= 1'b0;
         output_relay_on <= 1'b0;
         main_supply_on <= 1'b0;
         aux_supply_on <= 1'b1;
         fans_full <= 1'b1;
         network_enable <= 1'b0;
         process_enable <= 1'b0;
         process_clear <= 1'b0;
      end else begin
         // open collector: drive low only while active, float otherwise
         contact_output_first_oe <= contact_output_first_act;
         contact_output_first_o <= 1'b0;
         contact_output_second_oe <= contact_output_second_act;
         contact_output_second_o <= 1'b0;
         if (!addr_valid_ff)
            status_lamp <= addr_zero_ff && blink_cnt_ff < PULSE_CYC;
         else if (control_ff[1])
            status_lamp <= fast_ph_ff;
         else
            status_lamp <= lamp_cnt_ff != 32'h0000_0000;
         // protection follows its inputs, so a cleared thermal trip self-recovers
         protect_lamp <= protect_now | muted_ff;
         output_relay_on <= ~protect_now & ~muted_ff & ~standby_now;
         out_lamp <= signal_near_full & ~short_circuit & ~protect_now;
         limit_lamp <= limiter_engaged;
         standby_lamp <= standby_now;
         main_supply_on <= ~standby_now & restored_ff;
         aux_supply_on <= 1'b1;
         fans_full <= muted_ff;
         network_enable <= addr_valid_ff;
         process_clear <= addr_done_ff & addr_zero_ff;
         process_enable <= addr_done_ff & addr_valid_ff & control_ff[2];
      end
   end
endmodule // amp_supervisor

/* File: core/amp_supervisor_map.vh */
// register offsets, fields and timing constants of the amplifier supervisor
// assumes a 25 MHz aclk and a 32-bit axi4-lite register bus
`ifndef AMP_SUPERVISOR_MAP_VH
`define AMP_SUPERVISOR_MAP_VH
// ========================================
// register byte offsets
`define REG_STATUS 12'h000
`define REG_CONTROL 12'h004
`define REG_CONTACT_FUNC 12'h008
`define REG_COND_MAP 12'h00C
`define REG_TRAFFIC 12'h010
`define REG_PROCESS 12'h014
// ========================================
// address limits
`define ADDR_STANDALONE 8'h00
`define ADDR_MAX 8'hFA
// ========================================
// contact input functions
`define FUNC_NONE 2'h0
`define FUNC_POWER 2'h1
`define FUNC_PRESET 2'h2
`define FUNC_PARAM 2'h3
// ========================================
// timing, figures in milliseconds, counts at 25 MHz
`define CLK_HZ 25000000
`define BLINK_MS 3000
`define LAMP_MIN_MS 100
`define MUTE_MS 2000
`define FAST_MS 62
`define PULSE_MS 100
`define DEBOUNCE_MS 10
`define MS_CYCLES(ms) ((ms) * (`CLK_HZ / 1000))
// ========================================
// reset values and axi response codes
`define CONTROL_RST 32'h0000_0000
`define CONTACT_FUNC_RST 32'h0000_0000
`define COND_MAP_RST 32'h0000_0000
`define AXI_OKAY 2'h0
`define AXI_DECERR 2'h3
`endif

/* File: testbench/amp_supervisor_assertions.sv */
// concurrent checks on the supervisor's pins
// assumes bind to amp_supervisor with the same mute length
module amp_supervisor_assertions #(
   parameter MUTE_CYC = 40
) (
   input wire aclk,
   input wire aresetn,
   input wire remote_power_in,
   input wire prot_thermal,
   input wire prot_other,
   input wire short_circuit,
   input wire limiter_engaged,
   input wire contact_output_first_o,
   input wire contact_output_second_o,
   input wire protect_lamp,
   input wire out_lamp,
   input wire limit_lamp,
   input wire output_relay_on,
   input wire main_supply_on,
   input wire aux_supply_on,
   input wire fans_full,
   input wire preset_recall_pulse,
   input wire param_step_pulse
);
   timeunit 1ns;
   timeprecision 1ps;
   int mute_cnt_ff;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ========================================
   // cycles since release, saturating so it never wraps
   always @(posedge aclk) begin
      if (!aresetn) mute_cnt_ff <= 0;
      else if (mute_cnt_ff < MUTE_CYC + 16) mute_cnt_ff <= mute_cnt_ff + 1;
   end
   sequence trip_end_s;
      $fell(prot_thermal) && (mute_cnt_ff > MUTE_CYC);
   endsequence
   sequence calm_s;
      (!prot_thermal && !prot_other && !short_circuit && remote_power_in)[*4];
   endsequence
   // ========================================
   // properties
   oc_never_high_a: assert property (!contact_output_first_o && !contact_output_second_o)
      else $error("contact output drives high");
   trip_opens_a: assert property (prot_other |=> protect_lamp && !output_relay_on)
      else $error("trip left relay closed");
   out_dims_a: assert property ((short_circuit || prot_other || prot_thermal) |=> !out_lamp)
      else $error("activity lamp lit under protection");
   limit_follows_a: assert property ($past(aresetn) |-> limit_lamp == $past(limiter_engaged))
      else $error("limit lamp not following limiter");
   standby_supply_a: assert property (!remote_power_in[*8] |-> !main_supply_on && aux_supply_on)
      else $error("remote standby kept main supply");
   mute_hold_a: assert property (mute_cnt_ff < MUTE_CYC / 2 |-> !output_relay_on && protect_lamp && fans_full)
      else $error("outputs connected during mute");
   thermal_back_a: assert property (trip_end_s ##1 calm_s |-> !protect_lamp)
      else $error("no recovery after thermal trip");
   pulse_single_a: assert property ((preset_recall_pulse || param_step_pulse) |=> !preset_recall_pulse && !param_step_pulse)
      else $error("contact pulse longer than one cycle");
endmodule // amp_supervisor_assertions

bind amp_supervisor amp_supervisor_assertions #(.MUTE_CYC(MUTE_CYC)) chk (.aclk, .aresetn,
   .remote_power_in, .prot_thermal, .prot_other, .short_circuit, .limiter_engaged,
   .contact_output_first_o, .contact_output_second_o, .protect_lamp, .out_lamp, .limit_lamp,
   .output_relay_on, .main_supply_on, .aux_supply_on, .fans_full, .preset_recall_pulse,
   .param_step_pulse);

/* File: testbench/ext_panel.sv */
// model of the control port wiring: two switches to ground, two loads on pull-ups
// assumes the supervisor's open-collector enables are high while pulling low
module ext_panel (
   input wire press_first,
   input wire press_second,
   input wire oe_first,
   input wire oe_second,
   output wire contact_input_first,
   output wire contact_input_second,
   output wire level_first,
   output wire level_second
);
   timeunit 1ns;
   timeprecision 1ps;
   // ========================================
   // pull-up wins unless the switch grounds the line
   assign contact_input_first = press_first ? 1'b0 : 1'b1;
   assign contact_input_second = press_second ? 1'b0 : 1'b1;
   // a released collector floats back to the load's pull-up
   assign level_first = oe_first ? 1'b0 : 1'b1;
   assign level_second = oe_second ? 1'b0 : 1'b1;
endmodule // ext_panel

/* File: testbench/testbench.sv */
// self-checking bench for amp_supervisor with short timing parameters
// assumes the register map header and the design sources are compiled alongside
`include "amp_supervisor_map.vh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam MUTE = 40;
   logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid, remote_power_in = 1, standby_retained = 0;
   logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb = 4'hF, addr_high_sel = 0, addr_low_sel = 1;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   logic can_traffic_seen = 0, can_tx_pulse = 0, prot_thermal = 0, prot_other = 0;
   logic short_circuit = 0, signal_near_full = 0, limiter_engaged = 0, temp_critical = 0;
   logic limit_crossed = 0, fault_seen = 0, sw1 = 0, sw2 = 0, in1, in2, lv1, lv2, mb;
   logic oe1, oe2, status_lamp, protect_lamp, out_lamp, limit_lamp, standby_lamp;
   logic output_relay_on, main_supply_on, aux_supply_on, fans_full, network_enable;
   logic process_enable, process_clear, preset_recall_pulse, param_step_pulse;
   int n_fail = 0, checked = 0, hi, rises, pp, qp;
   // ========================================
   // clock, design and switch panel
   always #20 aclk = ~aclk;
   amp_supervisor #(.BLINK_CYC(60), .LAMP_CYC(10), .MUTE_CYC(MUTE), .FAST_CYC(3),
      .PULSE_CYC(5), .DEB_CYC(4)) DUT (.*, .contact_input_first(in1),
      .contact_input_second(in2), .contact_output_first_oe(oe1),
      .contact_output_first_o(), .contact_output_second_oe(oe2), .contact_output_second_o());
   ext_panel panel (.press_first(sw1), .press_second(sw2), .oe_first(oe1), .oe_second(oe2),
      .contact_input_first(in1), .contact_input_second(in2), .level_first(lv1),
      .level_second(lv2));
   // ========================================
   // shared tasks
   task automatic chk(input logic [63:0] g, e);
      checked++;
      if (g !== e) begin
         n_fail++;
         $display("Error %0t: got %h want %h", $time, g, e);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
      end while (!s_axi_bvalid);
      rs = s_axi_bresp;
      s_axi_bready <= 0;
   endtask
   task automatic rdr(input logic [11:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 0;
      end while (!s_axi_rvalid);
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 0;
   endtask
   // lamp highs and rises, contact pulses, accumulated over n cycles
   task automatic watch(input int n);
      logic last = 0;
      repeat (n) begin
         @(posedge aclk);
         hi += status_lamp;
         rises += (status_lamp && !last);
         last = status_lamp;
         pp += preset_recall_pulse;
         qp += param_step_pulse;
      end
   endtask
   task automatic do_reset(input logic [7:0] a, input logic keep);
      @(posedge aclk);
      aresetn <= 0;
      {addr_high_sel, addr_low_sel} <= a;
      standby_retained <= keep;
      cyc(20);
      aresetn <= 1;
      cyc(10);
      chk({output_relay_on, protect_lamp, fans_full}, 3'b011);
      cyc(MUTE);
      hi = 0;
      rises = 0;
      pp = 0;
      qp = 0;
   endtask
   // ========================================
   // scenarios
   task automatic t_regs;
      chk(output_relay_on, 1);
      rdr(`REG_CONTROL);
      chk({rs, rd}, {`AXI_OKAY, `CONTROL_RST});
      rdr(12'h020);
      chk({rs, rd}, {`AXI_DECERR, 32'h0000_0000});
      wr(12'h020, 32'h0000_0007);
      chk(rs, `AXI_DECERR);
      wr(`REG_CONTROL, 32'h0000_0004);
      cyc(1);
      chk(process_enable, 1);
      wr(`REG_CONTROL, 32'h0000_0000);
   endtask
   task automatic t_lamp;
      can_traffic_seen <= 1;
      cyc(2);
      can_traffic_seen <= 0;
      can_tx_pulse <= 1;
      cyc(1);
      can_tx_pulse <= 0;
      watch(40);
      chk(hi >= 10, 1);
      rdr(`REG_TRAFFIC);
      chk(rd[1:0], 2'h3);
      wr(`REG_TRAFFIC, 32'h0000_0003);
      wr(`REG_CONTROL, 32'h0000_0002);
      rises = 0;
      watch(40);
      chk(rises >= 4, 1);
      wr(`REG_CONTROL, 32'h0000_0000);
      cyc(4);
      hi = 0;
      watch(40);
      chk(hi, 0);
   endtask
   task automatic t_contacts;
      int md;
      for (int m = 0; m < 5; m++) begin
         md = (m + 1) % 4;
         wr(`REG_CONTACT_FUNC, md);
         mb = main_supply_on;
         pp = 0;
         qp = 0;
         sw1 <= 1;
         watch(15);
         sw1 <= 0;
         watch(15);
         chk({pp, qp}, {int'(md == 2), int'(md == 3)});
         chk(main_supply_on !== mb, md == 1);
      end
      wr(`REG_CONTACT_FUNC, 32'h0000_0008);
      sw2 <= 1;
      watch(15);
      sw2 <= 0;
      watch(15);
      chk(pp, 1);
   endtask
   task automatic t_cond;
      wr(`REG_COND_MAP, 32'h0000_0082);
      temp_critical <= 1;
      cyc(3);
      chk({oe1, oe2, lv1, lv2}, 4'b1001);
      temp_critical <= 0;
      fault_seen <= 1;
      cyc(3);
      chk({oe1, oe2, lv1, lv2}, 4'b0110);
      fault_seen <= 0;
      limit_crossed <= 1;
      cyc(3);
      chk({oe1, oe2}, 2'b00);
      limit_crossed <= 0;
   endtask
   task automatic t_protect;
      signal_near_full <= 1;
      cyc(3);
      chk({out_lamp, protect_lamp, output_relay_on}, 3'b101);
      prot_other <= 1;
      cyc(3);
      chk({out_lamp, protect_lamp, output_relay_on}, 3'b010);
      prot_other <= 0;
      short_circuit <= 1;
      cyc(3);
      chk(out_lamp, 0);
      short_circuit <= 0;
      prot_thermal <= 1;
      cyc(3);
      chk({protect_lamp, output_relay_on}, 2'b10);
      prot_thermal <= 0;
      cyc(6);
      chk({protect_lamp, output_relay_on}, 2'b01);
      limiter_engaged <= 1;
      cyc(3);
      chk(limit_lamp, 1);
      limiter_engaged <= 0;
      signal_near_full <= 0;
   endtask
   task automatic t_standby;
      remote_power_in <= 0;
      cyc(10);
      chk({main_supply_on, aux_supply_on, standby_lamp}, 3'b011);
      remote_power_in <= 1;
      cyc(10);
      chk(main_supply_on, 1);
      wr(`REG_CONTROL, 32'h0000_0001);
      cyc(3);
      chk({main_supply_on, aux_supply_on}, 2'b01);
      wr(`REG_CONTROL, 32'h0000_0000);
   endtask
   task automatic t_address;
      logic [7:0] tab [5] = '{8'h00, 8'h01, 8'h5C, 8'hFA, 8'hFB};
      logic ok;
      foreach (tab[i]) begin
         do_reset(tab[i], 0);
         ok = (tab[i] != 0) && (tab[i] <= `ADDR_MAX);
         rdr(`REG_STATUS);
         chk({rd[23:16], rd[1:0]}, {tab[i], tab[i] == 0, ok});
         chk(network_enable, ok);
         watch(120);
         if (tab[i] == 0) chk({process_clear, process_enable, hi}, {2'b10, 32'd10});
         if (tab[i] == 8'hFB) chk(hi, 0);
      end
      do_reset(8'h01, 1);
      chk({main_supply_on, standby_lamp}, 2'b01);
   endtask
   task automatic report_and_stop;
      if (n_fail == 0 && checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // ========================================
   // main sequence and watchdog
   initial begin
      do_reset(8'h01, 0);
      t_regs();
      t_lamp();
      t_contacts();
      t_cond();
      t_protect();
      t_standby();
      t_address();
      report_and_stop();
   end
   initial begin
      repeat (20000) @(posedge aclk);
      n_fail++;
      report_and_stop();
   end
endmodule // testbench
